/* hpdc_pkg.sv */
package hpdc_pkg;
  localparam int          CHANNELS          = 14;
  localparam int          CASCADE_COUNT     = 5;
  localparam int          ADDR_W            = 11;
  localparam int          DATA_W            = 8;
  localparam int          SEL_MSB           = 10;
  localparam int          SEL_LSB           = 8;
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          HW_RESET_MIN_NS   = 10000;
  localparam int          HW_RESET_CYCLES   = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          HW_RESET_CNT_W    = 8;
  localparam logic [2:0]  SEL_MASTER        = 3'h0;
  localparam logic [2:0]  SEL_RESERVED      = 3'h6;
  localparam logic [2:0]  SEL_ALL           = 3'h7;
  localparam logic [2:0]  HOST_STROBE       = 3'h0;
  localparam logic [2:0]  HOST_XFER_ACK     = 3'h1;
  localparam logic [2:0]  HOST_SYNC         = 3'h7;
  localparam logic [7:0]  CHAN_REG_BASE     = 8'h00;
  localparam logic [7:0]  GLOBAL_REG_ADDR   = 8'he0;
  localparam logic [7:0]  STATUS_LO_ADDR    = 8'he1;
  localparam logic [7:0]  STATUS_HI_ADDR    = 8'he2;
  localparam int          CHAN_RX_ON_BIT    = 0;
  localparam int          CHAN_TERM_BIT     = 1;
  localparam int          GLB_IRQ_EN_BIT    = 0;
  localparam int          GLB_TERM_PIN_BIT  = 1;
  localparam logic [1:0]  CHAN_REG_RESET    = 2'h0;
  localparam logic [1:0]  GLOBAL_REG_RESET  = 2'h0;
  localparam logic [7:0]  DATA_ZERO         = 8'h00;
endpackage

/* hpdc_reset_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module hpdc_reset_filter
  import hpdc_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  wire logic i_hw_reset_n,
  output logic      o_hw_reset
);
  logic [HW_RESET_CNT_W-1:0] low_cnt_reg;
  logic [HW_RESET_CNT_W-1:0] low_cnt_next;
  logic                      hw_reset_reg;
  logic                      hw_reset_next;

  // a glitch shorter than the minimum low time never reaches the registers
  always_comb begin
    low_cnt_next  = low_cnt_reg;
    hw_reset_next = 1'b0;
    if (i_hw_reset_n) begin
      low_cnt_next = '0;
    end else if (low_cnt_reg < HW_RESET_CNT_W'(HW_RESET_CYCLES)) begin
      low_cnt_next = low_cnt_reg + 1'b1;
    end else begin
      hw_reset_next = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      low_cnt_reg  <= '0;
      hw_reset_reg <= 1'b0;
    end else begin
      low_cnt_reg  <= low_cnt_next;
      hw_reset_reg <= hw_reset_next;
    end
  end

  assign o_hw_reset = hw_reset_reg;
endmodule
`default_nettype wire

/* hpdc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module hpdc_top
  import hpdc_pkg::*;
(
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_nrst,
  input  wire logic                     i_cs_n,
  input  wire logic [ADDR_W-1:0]        i_addr,
  input  wire logic [DATA_W-1:0]        i_data,
  input  wire logic                     i_wr_n_or_read_write,
  input  wire logic                     i_rd_n_or_write_enable_n,
  input  wire logic                     i_address_latch_or_transfer_start,
  input  wire logic                     i_upclk,
  input  wire logic [2:0]               i_host_type_select,
  input  wire logic                     i_hw_reset_n,
  input  wire logic                     i_receiver_power_pin,
  input  wire logic                     i_rx_termination_pin,
  input  wire logic [CHANNELS-1:0]      i_alarm_status,
  output logic      [DATA_W-1:0]        o_data,
  output logic                          o_data_oe,
  output logic                          o_ready_or_transfer_ack_n,
  output logic                          o_irq_n,
  output logic                          o_irq_oe,
  output logic      [CASCADE_COUNT-1:0] o_cascade_select_n,
  output logic      [CHANNELS-1:0]      o_rx_power_on,
  output logic      [CHANNELS-1:0]      o_rx_termination_on
);
  logic                     hw_reset;
  logic                     regs_clear;

  logic                     upclk_prev_reg;
  logic [ADDR_W-1:0]        addr_latch_reg;
  logic [ADDR_W-1:0]        addr_latch_next;
  logic                     busy_reg;
  logic                     busy_next;
  logic                     read_reg;
  logic                     read_next;
  logic [DATA_W-1:0]        rdata_reg;
  logic [DATA_W-1:0]        rdata_next;
  logic                     ack_n_reg;
  logic                     ack_n_next;
  logic                     oe_reg;
  logic                     oe_next;
  logic [CASCADE_COUNT-1:0] csel_n_reg;
  logic [CASCADE_COUNT-1:0] csel_n_next;

  logic [1:0]               chan_reg  [CHANNELS];
  logic [1:0]               chan_next [CHANNELS];
  logic [1:0]               global_reg;
  logic [1:0]               global_next;
  logic [CHANNELS-1:0]      alarm_prev_reg;
  logic [CHANNELS-1:0]      changed_reg;
  logic [CHANNELS-1:0]      changed_next;
  logic                     irq_n_reg;
  logic                     irq_n_next;
  logic                     irq_oe_reg;
  logic                     irq_oe_next;
  logic [CHANNELS-1:0]      rx_on_reg;
  logic [CHANNELS-1:0]      rx_on_next;
  logic [CHANNELS-1:0]      term_reg;
  logic [CHANNELS-1:0]      term_next;

  logic                     sync_mode;
  logic                     upclk_rise;
  logic [ADDR_W-1:0]        addr_eff;
  logic [2:0]               dev_sel;
  logic [7:0]               reg_addr;
  logic                     self_sel;
  logic                     strobe_act;
  logic                     strobe_read;
  logic                     start;
  logic                     done;
  logic                     wr_take;
  logic                     rd_take;

  hpdc_reset_filter u_reset_filter (
    .i_sys_clk    (i_sys_clk),
    .i_nrst       (i_nrst),
    .i_hw_reset_n (i_hw_reset_n),
    .o_hw_reset   (hw_reset)
  );

  assign regs_clear = !i_nrst || hw_reset;

  function automatic logic [CASCADE_COUNT-1:0] cascade_decode(input logic [2:0] sel);
    logic [CASCADE_COUNT-1:0] act;
    act = '0;
    if (sel == SEL_ALL) begin
      act = '1;
    end else if (sel != SEL_MASTER && sel != SEL_RESERVED) begin
      act[sel - 3'h1] = 1'b1;
    end
    return act;
  endfunction

  function automatic logic [DATA_W-1:0] read_mux(input logic [7:0] a, input logic [1:0] glb,
                                                 input logic [CHANNELS-1:0] chg,
                                                 input logic [1:0] chan [CHANNELS]);
    logic [DATA_W-1:0] d;
    d = DATA_ZERO;
    if (a == GLOBAL_REG_ADDR) begin
      d = {6'h00, glb};
    end else if (a == STATUS_LO_ADDR) begin
      d = chg[7:0];
    end else if (a == STATUS_HI_ADDR) begin
      d = {2'h0, chg[CHANNELS-1:8]};
    end else if (a < CHAN_REG_BASE + 8'(CHANNELS)) begin
      d = {6'h00, chan[4'(a - CHAN_REG_BASE)]};
    end
    return d;
  endfunction

  // decode and access detection
  assign sync_mode  = (i_host_type_select == HOST_SYNC);
  assign upclk_rise = i_upclk && !upclk_prev_reg;
  assign addr_eff   = (i_host_type_select == HOST_STROBE) ? addr_latch_reg : i_addr;
  assign dev_sel    = addr_eff[SEL_MSB:SEL_LSB];
  assign reg_addr   = addr_eff[7:0];
  assign self_sel   = (dev_sel == SEL_MASTER) || (dev_sel == SEL_ALL);

  always_comb begin
    strobe_act  = 1'b0;
    strobe_read = 1'b0;
    if (i_host_type_select == HOST_STROBE) begin
      strobe_act  = !i_rd_n_or_write_enable_n || !i_wr_n_or_read_write;
      strobe_read = !i_rd_n_or_write_enable_n;
    end else if (i_host_type_select == HOST_XFER_ACK) begin
      strobe_act  = !i_rd_n_or_write_enable_n;
      strobe_read = i_wr_n_or_read_write;
    end else if (sync_mode) begin
      strobe_act  = i_address_latch_or_transfer_start;
      strobe_read = i_wr_n_or_read_write;
    end
  end

  // other host type codes are unsupported and never start an access
  always_comb begin
    if (sync_mode) begin
      start = !i_cs_n && upclk_rise && strobe_act;
      done  = busy_reg && (i_cs_n || (upclk_rise && !strobe_act));
    end else begin
      start = !i_cs_n && strobe_act && !busy_reg;
      done  = busy_reg && (i_cs_n || !strobe_act);
    end
  end

  assign rd_take = start && self_sel && strobe_read;
  assign wr_take = start && self_sel && !strobe_read;

  // host access sequencing
  always_comb begin
    addr_latch_next = addr_latch_reg;
    busy_next       = busy_reg;
    read_next       = read_reg;
    rdata_next      = rdata_reg;
    ack_n_next      = 1'b1;
    oe_next         = 1'b0;
    if (i_address_latch_or_transfer_start) begin
      addr_latch_next = i_addr;
    end
    if (start) begin
      busy_next = 1'b1;
      read_next = strobe_read;
    end else if (done) begin
      busy_next = 1'b0;
    end
    if (rd_take) begin
      rdata_next = read_mux(reg_addr, global_reg, changed_reg, chan_reg);
    end
    if (start && self_sel) begin
      ack_n_next = 1'b0;
      oe_next    = strobe_read;
    end else if (busy_reg && !done && self_sel) begin
      ack_n_next = 1'b0;
      oe_next    = read_reg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      upclk_prev_reg <= 1'b0;
      addr_latch_reg <= '0;
      busy_reg       <= 1'b0;
      read_reg       <= 1'b0;
      rdata_reg      <= '0;
      ack_n_reg      <= 1'b1;
      oe_reg         <= 1'b0;
    end else begin
      upclk_prev_reg <= i_upclk;
      addr_latch_reg <= addr_latch_next;
      busy_reg       <= busy_next;
      read_reg       <= read_next;
      rdata_reg      <= rdata_next;
      ack_n_reg      <= ack_n_next;
      oe_reg         <= oe_next;
    end
  end

  // cascade selects follow the chip select window, not the strobes
  always_comb begin
    csel_n_next = '1;
    if (!i_cs_n) begin
      csel_n_next = ~cascade_decode(dev_sel);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      csel_n_reg <= '1;
    end else begin
      csel_n_reg <= csel_n_next;
    end
  end

  // configuration registers
  always_comb begin
    global_next = global_reg;
    for (int i = 0; i < CHANNELS; i++) begin
      chan_next[i] = chan_reg[i];
    end
    if (wr_take) begin
      if (reg_addr == GLOBAL_REG_ADDR) begin
        global_next = i_data[1:0];
      end else if (reg_addr < CHAN_REG_BASE + 8'(CHANNELS)) begin
        chan_next[4'(reg_addr - CHAN_REG_BASE)] = i_data[1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (regs_clear) begin
      global_reg <= GLOBAL_REG_RESET;
      for (int i = 0; i < CHANNELS; i++) begin
        chan_reg[i] <= CHAN_REG_RESET;
      end
    end else begin
      global_reg <= global_next;
      for (int i = 0; i < CHANNELS; i++) begin
        chan_reg[i] <= chan_next[i];
      end
    end
  end

  // alarm change flags; a change in the reading cycle survives the clear
  always_comb begin
    changed_next = changed_reg;
    if (rd_take && reg_addr == STATUS_LO_ADDR) begin
      changed_next[7:0] = '0;
    end
    if (rd_take && reg_addr == STATUS_HI_ADDR) begin
      changed_next[CHANNELS-1:8] = '0;
    end
    changed_next = changed_next | (i_alarm_status ^ alarm_prev_reg);
    irq_n_next   = !(global_reg[GLB_IRQ_EN_BIT] && (|changed_reg));
    irq_oe_next  = !irq_n_next;
  end

  always_ff @(posedge i_sys_clk) begin
    if (regs_clear) begin
      alarm_prev_reg <= '0;
      changed_reg    <= '0;
      irq_n_reg      <= 1'b1;
      irq_oe_reg     <= 1'b0;
    end else begin
      alarm_prev_reg <= i_alarm_status;
      changed_reg    <= changed_next;
      irq_n_reg      <= irq_n_next;
      irq_oe_reg     <= irq_oe_next;
    end
  end

  // receiver power and termination
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      rx_on_next[i] = i_receiver_power_pin && chan_reg[i][CHAN_RX_ON_BIT];
      if (global_reg[GLB_TERM_PIN_BIT]) begin
        term_next[i] = i_rx_termination_pin;
      end else begin
        term_next[i] = chan_reg[i][CHAN_TERM_BIT];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (regs_clear) begin
      rx_on_reg <= '0;
      term_reg  <= '0;
    end else begin
      rx_on_reg <= rx_on_next;
      term_reg  <= term_next;
    end
  end

  assign o_data                    = rdata_reg;
  assign o_data_oe                 = oe_reg;
  assign o_ready_or_transfer_ack_n = ack_n_reg;
  assign o_irq_n                   = irq_n_reg;
  // open drain: only ever pulls low
  assign o_irq_oe                  = irq_oe_reg;
  assign o_cascade_select_n        = csel_n_reg;
  assign o_rx_power_on             = rx_on_reg;
  assign o_rx_termination_on       = term_reg;
endmodule
`default_nettype wire

/* hpdc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module hpdc_props
  import hpdc_pkg::*;
(
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_nrst,
  input  wire logic                     i_cs_n,
  input  wire logic [ADDR_W-1:0]        i_addr,
  input  wire logic                     i_upclk,
  input  wire logic [2:0]               i_host_type_select,
  input  wire logic                     i_hw_reset_n,
  input  wire logic                     i_receiver_power_pin,
  input  wire logic                     o_data_oe,
  input  wire logic                     o_ready_or_transfer_ack_n,
  input  wire logic                     o_irq_n,
  input  wire logic                     o_irq_oe,
  input  wire logic [CASCADE_COUNT-1:0] o_cascade_select_n,
  input  wire logic [CHANNELS-1:0]      o_rx_power_on,
  input  wire logic [CHANNELS-1:0]      o_rx_termination_on
);
  logic [7:0] low_cnt_reg;
  logic [7:0] low_cnt_next;
  logic [2:0] sel;
  assign sel = i_addr[SEL_MSB:SEL_LSB];
  // saturates so a very long reset low never wraps back under the threshold
  always_comb begin
    low_cnt_next = (low_cnt_reg == 8'hff) ? low_cnt_reg : low_cnt_reg + 8'h01;
    if (i_hw_reset_n) begin
      low_cnt_next = 8'h00;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    low_cnt_reg <= low_cnt_next;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_idle2;
    i_cs_n [*2];
  endsequence
  sequence s_sync_no_rise;
    !i_cs_n && i_host_type_select == HOST_SYNC && !(i_upclk && !$past(i_upclk)) && o_ready_or_transfer_ack_n;
  endsequence
  property p_irq_oe;
    o_irq_oe == !o_irq_n;
  endproperty
  a_irq_oe: assert property (p_irq_oe) else $error("irq enable does not match irq");
  property p_rx_off;
    !i_receiver_power_pin |=> o_rx_power_on == '0;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver on with enable pin low");
  property p_cs_idle;
    i_cs_n |=> &o_cascade_select_n;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("cascade select without chip select");
  property p_all_sel;
    !i_cs_n && i_host_type_select != HOST_STROBE && sel == SEL_ALL |=> o_cascade_select_n == '0;
  endproperty
  a_all_sel: assert property (p_all_sel) else $error("broadcast selects wrong");
  property p_one_sel;
    !i_cs_n && i_host_type_select != HOST_STROBE && sel inside {[3'h1:3'h5]}
    |=> o_cascade_select_n == 5'(~(5'h01 << ($past(sel) - 3'h1)));
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("single cascade select wrong");
  property p_idle_ack;
    s_idle2 |=> o_ready_or_transfer_ack_n && !o_data_oe;
  endproperty
  a_idle_ack: assert property (p_idle_ack) else $error("answer while not selected");
  property p_oe_ack;
    $rose(o_data_oe) |-> $fell(o_ready_or_transfer_ack_n);
  endproperty
  a_oe_ack: assert property (p_oe_ack) else $error("data driven outside a read answer");
  property p_bad_type;
    (i_host_type_select inside {[3'h2:3'h6]}) [*2] |=> o_ready_or_transfer_ack_n;
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("answer under unsupported host type");
  property p_sync_rise;
    s_sync_no_rise |=> o_ready_or_transfer_ack_n;
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("sync access without clock rise");
  property p_hw_reset;
    low_cnt_reg >= 8'(HW_RESET_CYCLES + 2) |-> o_rx_power_on == '0 && o_rx_termination_on == '0 && o_irq_n;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("outputs not cleared by long reset");
endmodule
bind hpdc_top hpdc_props u_props (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cs_n(i_cs_n), .i_addr(i_addr),
  .i_upclk(i_upclk), .i_host_type_select(i_host_type_select), .i_hw_reset_n(i_hw_reset_n),
  .i_receiver_power_pin(i_receiver_power_pin), .o_data_oe(o_data_oe),
  .o_ready_or_transfer_ack_n(o_ready_or_transfer_ack_n), .o_irq_n(o_irq_n), .o_irq_oe(o_irq_oe),
  .o_cascade_select_n(o_cascade_select_n), .o_rx_power_on(o_rx_power_on),
  .o_rx_termination_on(o_rx_termination_on));
`default_nettype wire

/* hpdc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hpdc_host_model
  import hpdc_pkg::*;
(
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_ack_n,
  input  wire logic [DATA_W-1:0]        i_data,
  input  wire logic [CASCADE_COUNT-1:0] i_cascade_n,
  output logic                          o_cs_n,
  output logic      [ADDR_W-1:0]        o_addr,
  output logic      [DATA_W-1:0]        o_data,
  output logic                          o_rw,
  output logic                          o_strobe_n,
  output logic                          o_ale,
  output logic                          o_upclk,
  output logic      [2:0]               o_host_type
);
  initial begin
    o_cs_n = 1'b1;
    o_addr = '0;
    o_data = '0;
    o_rw = 1'b1;
    o_strobe_n = 1'b1;
    o_ale = 1'b0;
    o_upclk = 1'b0;
    o_host_type = HOST_STROBE;
  end
  task automatic set_mode(input logic [2:0] m);
    @(posedge i_sys_clk);
    o_host_type <= m;
    // let the new type settle before the next access branches on it
    @(posedge i_sys_clk);
  endtask
  // request held until acknowledge; eight edges without one counts as refused
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic acked, output logic [DATA_W-1:0] q, output logic [CASCADE_COUNT-1:0] sel_n);
    int n;
    o_addr <= a;
    o_data <= d;
    if (o_host_type == HOST_STROBE) begin
      o_ale <= 1'b1;
      @(posedge i_sys_clk);
      o_ale <= 1'b0;
      o_strobe_n <= wr;
    end else begin
      o_strobe_n <= 1'b0;
      o_ale <= (o_host_type == HOST_SYNC);
    end
    o_rw <= !wr;
    o_cs_n <= 1'b0;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      // one rise per access; the release drops it on the exit edge
      if (n == 0) begin
        o_upclk <= 1'b1;
      end
      n++;
    end while (i_ack_n !== 1'b0 && n < 8);
    acked = (i_ack_n === 1'b0);
    q = i_data;
    sel_n = i_cascade_n;
    o_cs_n <= 1'b1;
    o_strobe_n <= 1'b1;
    o_rw <= 1'b1;
    o_ale <= 1'b0;
    o_upclk <= 1'b0;
    // released lines show garbage rather than the last value
    o_addr <= ~a;
    o_data <= ~d;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (i_ack_n !== 1'b1 && n < 8);
  endtask
endmodule
`default_nettype wire

/* hpdc_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module hpdc_top_bench;
  import hpdc_pkg::*;
  logic clk = 1'b0;
  logic nrst, hw_reset_n, rx_pin, term_pin, ack, cs_n, rw, strobe_n, ale, upclk, ack_n, oe, irq_oe, irq_line, irq_n;
  logic [CHANNELS-1:0] alarm, rx_power, rx_term;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] q, host_data, dev_data, bus;
  logic [4:0] seln, casc_n, exp_sel;
  logic [2:0] htype;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  assign bus = oe ? dev_data : host_data;
  assign irq_line = irq_oe ? 1'b0 : 1'b1;
  hpdc_top dut (.i_sys_clk(clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_addr(addr), .i_data(bus),
    .i_wr_n_or_read_write(rw), .i_rd_n_or_write_enable_n(strobe_n), .i_address_latch_or_transfer_start(ale),
    .i_upclk(upclk), .i_host_type_select(htype), .i_hw_reset_n(hw_reset_n), .i_receiver_power_pin(rx_pin),
    .i_rx_termination_pin(term_pin), .i_alarm_status(alarm), .o_data(dev_data), .o_data_oe(oe),
    .o_ready_or_transfer_ack_n(ack_n), .o_irq_n(irq_n), .o_irq_oe(irq_oe), .o_cascade_select_n(casc_n),
    .o_rx_power_on(rx_power), .o_rx_termination_on(rx_term));
  hpdc_host_model host (.i_sys_clk(clk), .i_ack_n(ack_n), .i_data(bus), .i_cascade_n(casc_n), .o_cs_n(cs_n),
    .o_addr(addr), .o_data(host_data), .o_rw(rw), .o_strobe_n(strobe_n), .o_ale(ale), .o_upclk(upclk),
    .o_host_type(htype));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, ack, q, seln);
  endtask
  task automatic rd_check(input string what, input logic [10:0] a, input logic [7:0] exp);
    host.xfer(1'b0, a, 8'h00, ack, q, seln);
    check(what, q, exp);
  endtask
  task automatic wait_edges(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    nrst = 1'b0;
    hw_reset_n = 1'b1;
    rx_pin = 1'b0;
    term_pin = 1'b0;
    alarm = '0;
    wait_edges(5);
    nrst <= 1'b1;
    wait_edges(1);
    check("rx_power", rx_power, 16'h0000);
    check("rx_term", rx_term, 16'h0000);
    check("cascade", casc_n, 16'h001f);
    wr(11'h000, 8'h03);
    wr(11'h00d, 8'h01);
    rx_pin <= 1'b1;
    wait_edges(2);
    check("rx_power", rx_power, 16'h2001);
    check("rx_term", rx_term, 16'h0001);
    rx_pin <= 1'b0;
    wait_edges(2);
    check("rx_power", rx_power, 16'h0000);
    wr(11'h0e0, 8'h02);
    term_pin <= 1'b1;
    wait_edges(2);
    check("rx_term", rx_term, 16'h3fff);
    term_pin <= 1'b0;
    wait_edges(2);
    check("rx_term", rx_term, 16'h0000);
    rd_check("global", 11'h0e0, 8'h02);
    rd_check("unmapped", 11'h0f0, 8'h00);
    host.set_mode(HOST_XFER_ACK);
    for (int s = 0; s < 8; s++) begin
      exp_sel = (s == 7) ? 5'h00 : 5'h1f;
      if (s >= 1 && s <= 5) exp_sel = 5'(~(5'h01 << (s - 1)));
      host.xfer(1'b0, {3'(s), 8'he0}, 8'h00, ack, q, seln);
      check("cascade", seln, exp_sel);
      check("ack", ack, (s == 0 || s == 7));
    end
    wr(11'h6e0, 8'h01);
    rd_check("reserved", 11'h0e0, 8'h02);
    wr(11'h700, 8'h01);
    rd_check("broadcast", 11'h000, 8'h01);
    alarm <= 14'h0008;
    wait_edges(4);
    check("irq", irq_line, 16'h0001);
    check("irq_n", irq_n, 16'h0001);
    rd_check("flags lo", 11'h0e1, 8'h08);
    wr(11'h0e0, 8'h03);
    alarm <= 14'h0208;
    wait_edges(4);
    check("irq", irq_line, 16'h0000);
    check("irq_n", irq_n, 16'h0000);
    rd_check("flags hi", 11'h0e2, 8'h02);
    wait_edges(3);
    check("irq", irq_line, 16'h0001);
    host.set_mode(HOST_SYNC);
    wr(11'h001, 8'h01);
    rd_check("sync", 11'h001, 8'h01);
    host.set_mode(3'h2);
    host.xfer(1'b0, 11'h001, 8'h00, ack, q, seln);
    check("bad type", ack, 16'h0000);
    host.set_mode(HOST_STROBE);
    hw_reset_n <= 1'b0;
    wait_edges(50);
    hw_reset_n <= 1'b1;
    wait_edges(2);
    rd_check("short reset", 11'h001, 8'h01);
    hw_reset_n <= 1'b0;
    wait_edges(110);
    hw_reset_n <= 1'b1;
    wait_edges(1);
    rd_check("long reset", 11'h001, 8'h00);
    rd_check("long reset", 11'h0e0, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
